// ==== design/usb_in_ep_regs.svh ====
`ifndef USB_IN_EP_REGS_SVH
`define USB_IN_EP_REGS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define IDX_ISO_UPD_CTL 8'h01
`define IDX_INDEX 8'h0e
`define IDX_IN_LOW 8'h11
`define IDX_IN_HIGH 8'h12
`define IDX_TOGGLE_STAT 8'h13
`define IDX_FIFO_DATA 8'h20

// ************************************************************
// in_endpoint_control_low fields
// ************************************************************
`define LOW_PKT_LOADED 0
`define LOW_FIFO_NOT_EMPTY 1
`define LOW_UNDERRUN 2
`define LOW_FLUSH 3
`define LOW_SEND_HALT 4
`define LOW_HALT_SENT 5
`define LOW_CLEAR_TOGGLE 6
`define LOW_RESET 8'h00

// ************************************************************
// in_endpoint_control_high fields
// ************************************************************
`define HIGH_FORCE_TOGGLE 3
`define HIGH_SPLIT 2
`define HIGH_DIR_SEL 5
`define HIGH_ISO 6
`define HIGH_DBUF 7

// ************************************************************
// misc
// ************************************************************
`define ISO_UPD_BIT 7
`define EP_FIRST 2'd1
`define EP_LAST 2'd3
`define SLOTS_SINGLE 2'd1
`define SLOTS_DOUBLE 2'd2

`endif

// ==== design/usb_in_ep_pkg.sv ====
package usb_in_ep_pkg;
`include "usb_in_ep_regs.svh"

	typedef enum logic [1:0] {RESP_DATA, RESP_ZLP, RESP_NAK, RESP_STALL} resp_kind_t;
	typedef enum logic {LINK_IDLE, LINK_WAIT_HS} link_state_t;

	// link side carriers
	typedef struct packed {logic valid; logic [1:0] ep;} token_t;
	typedef struct packed {logic valid; logic ack;} handshake_t;
	typedef struct packed {logic valid; resp_kind_t kind; logic toggle; logic [1:0] ep;} resp_t;
	typedef struct packed {logic en; logic [1:0] ep; logic [7:0] data;} fifo_wr_t;

	// per endpoint state
	typedef struct packed {logic dbuf; logic iso; logic dir_sel; logic force_tog; logic split;} ep_cfg_t;
	typedef struct packed
	{
		logic send_halt;
		logic halt_sent;
		logic underrun;
		logic toggle;
		logic flush_busy;
		logic has_data;
	} ep_ctl_t;
	typedef struct packed {logic [1:0] cnt; logic [1:0] zlp; logic held;} slot_state_t;
	typedef struct packed {logic pready; logic pslverr; logic [31:0] prdata;} apb_state_t;

	// endpoint packet capacity
	function automatic logic [1:0] slot_cap(input ep_cfg_t c);
		slot_cap = c.dbuf ? `SLOTS_DOUBLE : `SLOTS_SINGLE;
	endfunction : slot_cap

	// endpoint serves the in direction
	function automatic logic in_capable(input ep_cfg_t c);
		in_capable = c.split | c.dir_sel;
	endfunction : in_capable

	// byte address of a register index
	function automatic logic [11:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'b00, idx, 2'b00};
	endfunction : byte_addr
endpackage : usb_in_ep_pkg

// ==== design/apb_reg_port.sv ====
`timescale 1ns/1ns
`default_nettype none
module apb_reg_port
	import usb_in_ep_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// register file side
	input wire logic hit,
	input wire logic [31:0] rdata,
	output logic wr_stb
);
	apb_state_t st_ff, nxt_st;

	// one wait state: answer registered so outputs come from flops
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.pready = 1'b0;
		if (psel && penable && !st_ff.pready)
		begin
			nxt_st.pready = 1'b1;
			nxt_st.pslverr = !hit;
			nxt_st.prdata = hit ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// write lands on the completing edge only
	assign wr_stb = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign prdata = st_ff.prdata;
endmodule : apb_reg_port
`default_nettype wire

// ==== design/in_pkt_slots.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "usb_in_ep_regs.svh"
module in_pkt_slots
	import usb_in_ep_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests
	input wire logic push,
	input wire logic push_zlp,
	input wire logic push_hold,
	input wire logic pop,
	input wire logic clear_all,
	input wire logic sof,
	// state
	output logic [1:0] cnt,
	output logic head_zlp,
	output logic held
);
	slot_state_t st_ff, nxt_st;

	// head of queue at zlp[0]; held marks the newest packet
	always_comb
	begin
		nxt_st = st_ff;
		if (sof)
			nxt_st.held = 1'b0;
		if (clear_all)
			nxt_st = '0;
		else
		begin
			if (pop && st_ff.cnt != 2'd0)
			begin
				nxt_st.zlp = {1'b0, st_ff.zlp[1]};
				nxt_st.cnt = st_ff.cnt - 2'd1;
				if (nxt_st.cnt == 2'd0)
					nxt_st.held = 1'b0;
			end
			if (push && nxt_st.cnt != `SLOTS_DOUBLE)
			begin
				nxt_st.zlp[nxt_st.cnt[0]] = push_zlp;
				nxt_st.cnt = nxt_st.cnt + 2'd1;
				nxt_st.held = push_hold;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign cnt = st_ff.cnt;
	assign head_zlp = st_ff.zlp[0];
	assign held = st_ff.held;
endmodule : in_pkt_slots
`default_nettype wire

// ==== design/usb_in_endpoint_control.sv ====
// Function
// - index register selects visible endpoint register set
// - split serves both directions, else one
// - iso bit picks isochronous or bulk/interrupt
// - interrupt on delivery, nonempty flush, stall
// - loaded packet sent on in token, interrupt
// - loaded without data sends zero length packet
// - send halt answers stall, not in iso
// - stall sets flag, flushes, clears loaded, interrupts
// - double buffer clears loaded flag without interrupt
// - force toggle flips on every queued packet sent, else on ack
// - iso without packet sends zlp, underrun
// - bulk nak sets underrun, software clears
// - iso update holds packet until next sof
// - clear toggle zeroes toggle, reads zero
// - flush drops one packet, self clears
// - fifo not empty reflects packet count
// - bit seven reads zero, reset zero
// - double buffer enable bit controls buffering
// - split gives upper half to in
// - unsplit direction select chooses in or out
`timescale 1ns/1ns
`default_nettype none
`include "usb_in_ep_regs.svh"
module usb_in_endpoint_control
	import usb_in_ep_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// serial engine side
	input wire token_t in_token,
	input wire handshake_t hs_in,
	input wire logic sof,
	output resp_t resp,
	// packet memory write port
	output fifo_wr_t fifo_wr,
	// endpoint interrupt pulses
	output logic [3:1] ep_irq
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed
	{
		logic [1:0] index;
		logic iso_upd;
		ep_cfg_t [3:1] cfg;
		ep_ctl_t [3:1] ctl;
		link_state_t link;
		logic [1:0] wait_ep;
		resp_t resp;
		fifo_wr_t fw;
		logic [3:1] irq;
	} top_state_t;

	top_state_t st_ff, nxt_st;
	logic wr_stb;
	logic hit;
	logic [31:0] rdata;
	logic [3:1] push, push_zlp, push_hold, pop, clear_all, head_zlp, held;
	logic [1:0] cnt [3:1];
	logic sel_ok;
	logic [7:0] low_rd;

	// ************************************************************
	// submodules
	// ************************************************************
	apb_reg_port u_apb
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.hit(hit),
		.rdata(rdata),
		.wr_stb(wr_stb)
	);

	// one packet queue per endpoint, packet data itself lives outside
	for (genvar e = 1; e <= 3; e++)
	begin : g_slots
		in_pkt_slots u_slots
		(
			.pclk(pclk),
			.presetn(presetn),
			.push(push[e]),
			.push_zlp(push_zlp[e]),
			.push_hold(push_hold[e]),
			.pop(pop[e]),
			.clear_all(clear_all[e]),
			.sof(sof),
			.cnt(cnt[e]),
			.head_zlp(head_zlp[e]),
			.held(held[e])
		);
	end

	// ************************************************************
	// register read decode
	// ************************************************************
	// only the indexed endpoint is visible
	assign sel_ok = st_ff.index >= `EP_FIRST && st_ff.index <= `EP_LAST;

	always_comb
	begin
		low_rd = `LOW_RESET;
		if (sel_ok)
		begin
			// loaded flag drops while a slot is still open
			// held packet reads as not loaded until sof
			low_rd[`LOW_PKT_LOADED] = cnt[st_ff.index] == slot_cap(st_ff.cfg[st_ff.index]) && !held[st_ff.index];
			// not empty while any packet queued
			low_rd[`LOW_FIFO_NOT_EMPTY] = cnt[st_ff.index] != 2'd0;
			low_rd[`LOW_UNDERRUN] = st_ff.ctl[st_ff.index].underrun;
			low_rd[`LOW_FLUSH] = st_ff.ctl[st_ff.index].flush_busy;
			low_rd[`LOW_SEND_HALT] = st_ff.ctl[st_ff.index].send_halt;
			low_rd[`LOW_HALT_SENT] = st_ff.ctl[st_ff.index].halt_sent;
		end
	end

	// clear toggle and bit seven read as zero via default
	always_comb
	begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			byte_addr(`IDX_INDEX): rdata[1:0] = st_ff.index;
			byte_addr(`IDX_ISO_UPD_CTL): rdata[`ISO_UPD_BIT] = st_ff.iso_upd;
			byte_addr(`IDX_IN_LOW): rdata[7:0] = low_rd;
			byte_addr(`IDX_IN_HIGH):
				if (sel_ok)
				begin
					rdata[`HIGH_DBUF] = st_ff.cfg[st_ff.index].dbuf;
					rdata[`HIGH_ISO] = st_ff.cfg[st_ff.index].iso;
					rdata[`HIGH_DIR_SEL] = st_ff.cfg[st_ff.index].dir_sel;
					rdata[`HIGH_FORCE_TOGGLE] = st_ff.cfg[st_ff.index].force_tog;
					rdata[`HIGH_SPLIT] = st_ff.cfg[st_ff.index].split;
				end
			byte_addr(`IDX_TOGGLE_STAT): rdata[0] = sel_ok && st_ff.ctl[st_ff.index].toggle;
			byte_addr(`IDX_FIFO_DATA): rdata = 32'h0000_0000;
			default: hit = 1'b0;
		endcase
	end

	// ************************************************************
	// next state: register writes, tokens, handshakes
	// ************************************************************
	always_comb
	begin
		logic [1:0] s;
		logic [1:0] t;
		s = st_ff.index;
		t = in_token.ep;
		nxt_st = st_ff;
		nxt_st.resp.valid = 1'b0;
		nxt_st.fw.en = 1'b0;
		nxt_st.irq = 3'b000;
		push = 3'b000;
		push_zlp = 3'b000;
		push_hold = 3'b000;
		pop = 3'b000;
		clear_all = 3'b000;
		// flush finishes in one cycle
		for (int e = 1; e <= 3; e++)
			nxt_st.ctl[e].flush_busy = 1'b0;

		// software writes; hardware sets below override clears
		if (wr_stb)
		begin
			unique case (paddr)
				byte_addr(`IDX_INDEX): nxt_st.index = pwdata[1:0];
				byte_addr(`IDX_ISO_UPD_CTL): nxt_st.iso_upd = pwdata[`ISO_UPD_BIT];
				byte_addr(`IDX_FIFO_DATA):
					if (sel_ok)
					begin
						nxt_st.fw.en = 1'b1;
						nxt_st.fw.ep = s;
						nxt_st.fw.data = pwdata[7:0];
						nxt_st.ctl[s].has_data = 1'b1;
					end
				byte_addr(`IDX_IN_HIGH):
					if (sel_ok)
					begin
						nxt_st.cfg[s].dbuf = pwdata[`HIGH_DBUF];
						nxt_st.cfg[s].iso = pwdata[`HIGH_ISO];
						nxt_st.cfg[s].dir_sel = pwdata[`HIGH_DIR_SEL];
						nxt_st.cfg[s].force_tog = pwdata[`HIGH_FORCE_TOGGLE];
						nxt_st.cfg[s].split = pwdata[`HIGH_SPLIT];
					end
				byte_addr(`IDX_IN_LOW):
					if (sel_ok)
					begin
						// commit without data queues a zero length packet
						// iso update holds the commit until sof
						if (pwdata[`LOW_PKT_LOADED])
						begin
							push[s] = cnt[s] != slot_cap(st_ff.cfg[s]); // commit into a full queue is dropped
							push_zlp[s] = !st_ff.ctl[s].has_data;
							push_hold[s] = st_ff.cfg[s].iso && st_ff.iso_upd;
							nxt_st.ctl[s].has_data = 1'b0;
						end
						// software sets and ends the halt
						nxt_st.ctl[s].send_halt = pwdata[`LOW_SEND_HALT];
						nxt_st.ctl[s].halt_sent = st_ff.ctl[s].halt_sent && pwdata[`LOW_HALT_SENT];
						nxt_st.ctl[s].underrun = st_ff.ctl[s].underrun && pwdata[`LOW_UNDERRUN];
						if (pwdata[`LOW_CLEAR_TOGGLE])
							nxt_st.ctl[s].toggle = 1'b0;
						// drop one packet; interrupt only if not empty
						if (pwdata[`LOW_FLUSH])
						begin
							nxt_st.ctl[s].flush_busy = 1'b1;
							pop[s] = 1'b1;
							nxt_st.irq[s] = cnt[s] != 2'd0;
						end
					end
				default: ;
			endcase
		end

		// in token from the serial engine
		if (st_ff.link == LINK_IDLE && in_token.valid && t != 2'd0 && in_capable(st_ff.cfg[t]))
		begin
			nxt_st.resp.valid = 1'b1;
			nxt_st.resp.ep = t;
			nxt_st.resp.toggle = st_ff.ctl[t].toggle;
			if (st_ff.cfg[t].iso)
			begin
				if (cnt[t] > {1'b0, held[t]})
				begin
					nxt_st.resp.kind = head_zlp[t] ? RESP_ZLP : RESP_DATA;
					pop[t] = 1'b1;
					nxt_st.irq[t] = 1'b1;
					// no handshake in iso, only forced flips
					if (st_ff.cfg[t].force_tog)
						nxt_st.ctl[t].toggle = !st_ff.ctl[t].toggle;
				end
				else
				begin
					// nothing ready sends zlp and flags underrun
					nxt_st.resp.kind = RESP_ZLP;
					nxt_st.ctl[t].underrun = 1'b1;
				end
			end
			else if (st_ff.ctl[t].send_halt)
			begin
				nxt_st.resp.kind = RESP_STALL;
				nxt_st.ctl[t].halt_sent = 1'b1;
				clear_all[t] = 1'b1;
				nxt_st.irq[t] = 1'b1;
			end
			// send head packet, wait for handshake
			else if (cnt[t] > {1'b0, held[t]})
			begin
				nxt_st.resp.kind = head_zlp[t] ? RESP_ZLP : RESP_DATA;
				nxt_st.link = LINK_WAIT_HS;
				nxt_st.wait_ep = t;
				if (st_ff.cfg[t].force_tog)
					nxt_st.ctl[t].toggle = !st_ff.ctl[t].toggle;
			end
			else
			begin
				nxt_st.resp.kind = RESP_NAK;
				nxt_st.ctl[t].underrun = 1'b1;
			end
		end

		// handshake closes a bulk/interrupt transmission
		if (st_ff.link == LINK_WAIT_HS && hs_in.valid)
		begin
			nxt_st.link = LINK_IDLE;
			// delivery pops the packet and interrupts
			if (hs_in.ack)
			begin
				pop[st_ff.wait_ep] = 1'b1;
				nxt_st.irq[st_ff.wait_ep] = 1'b1;
				// unforced toggle flips on ack only
				if (!st_ff.cfg[st_ff.wait_ep].force_tog)
					nxt_st.ctl[st_ff.wait_ep].toggle = !st_ff.ctl[st_ff.wait_ep].toggle;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign resp = st_ff.resp;
	assign fifo_wr = st_ff.fw;
	assign ep_irq = st_ff.irq;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic tok_take;
	assign tok_take = st_ff.link == LINK_IDLE && in_token.valid && in_token.ep != 2'd0
		&& in_capable(st_ff.cfg[in_token.ep]);

	a_token_answer: assert property (tok_take |=> resp.valid && resp.ep == $past(in_token.ep))
		else $error("in token not answered next cycle");
	a_halt_answer: assert property (tok_take && !st_ff.cfg[in_token.ep].iso
		&& st_ff.ctl[in_token.ep].send_halt |=> resp.kind == RESP_STALL)
		else $error("halt requested but no stall sent");
	a_stall_effects: assert property (resp.valid && resp.kind == RESP_STALL
		|-> st_ff.ctl[resp.ep].halt_sent && ep_irq[resp.ep] && cnt[resp.ep] == 2'd0)
		else $error("stall without flag, flush or interrupt");
	a_nak_underrun: assert property (resp.valid && resp.kind == RESP_NAK |-> st_ff.ctl[resp.ep].underrun)
		else $error("nak without underrun flag");
	a_iso_underrun: assert property (tok_take && st_ff.cfg[in_token.ep].iso
		&& cnt[in_token.ep] == 2'd0 |=> resp.kind == RESP_ZLP && st_ff.ctl[resp.ep].underrun)
		else $error("iso underrun not reported");
	a_toggle_clear: assert property (wr_stb && paddr == byte_addr(`IDX_IN_LOW) && sel_ok
		&& pwdata[`LOW_CLEAR_TOGGLE] && !tok_take && st_ff.link == LINK_IDLE
		|=> !st_ff.ctl[$past(st_ff.index)].toggle)
		else $error("clear toggle did not zero toggle");
	a_flush_done: assert property (st_ff.ctl[1].flush_busy |=> !st_ff.ctl[1].flush_busy)
		else $error("flush bit stuck");
	a_unmapped_zero: assert property (pready && !sel_ok && paddr == byte_addr(`IDX_IN_LOW)
		|-> prdata == 32'h0000_0000)
		else $error("unselected endpoint leaks status");
	a_ack_irq: assert property (st_ff.link == LINK_WAIT_HS && hs_in.valid && hs_in.ack
		|=> ep_irq[$past(st_ff.wait_ep)] && st_ff.link == LINK_IDLE)
		else $error("delivery without interrupt");

	c_stall: cover property (resp.valid && resp.kind == RESP_STALL);
	c_ack: cover property (st_ff.link == LINK_WAIT_HS ##1 hs_in.valid && hs_in.ack);
	c_iso_zlp: cover property (resp.valid && resp.kind == RESP_ZLP && st_ff.cfg[resp.ep].iso);
	c_double: cover property (cnt[1] == `SLOTS_DOUBLE);
endmodule : usb_in_endpoint_control
`default_nettype wire

// ==== verification/usb_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
	import usb_in_ep_pkg::*;
(
	// clock
	input wire logic pclk,
	// link towards the endpoint logic
	input wire resp_t resp,
	output token_t in_token,
	output handshake_t hs_in,
	output logic sof
);
	// link idle at time zero
	initial
	begin
		in_token = '0;
		hs_in = '0;
		sof = 1'b0;
	end

	// ************************************************************
	// in token, answer, optional handshake after a gap
	// ************************************************************
	task automatic xfer(input logic [1:0] ep, input logic bulk, input logic ack, input int gap, output resp_t r);
		@(posedge pclk);
		in_token <= {1'b1, ep};
		@(posedge pclk);
		in_token <= '0;
		@(negedge pclk);
		r = resp;
		// only bulk data needs a handshake; a slow host waits longer
		if (bulk && r.valid === 1'b1 && (r.kind === RESP_DATA || r.kind === RESP_ZLP))
		begin
			repeat (gap) @(posedge pclk);
			hs_in <= {1'b1, ack};
			@(posedge pclk);
			hs_in <= '0;
		end
	endtask : xfer

	// start of frame pulse
	task automatic frame;
		@(posedge pclk);
		sof <= 1'b1;
		@(posedge pclk);
		sof <= 1'b0;
	endtask : frame
endmodule : usb_host_model
`default_nettype wire

// ==== verification/tb_usb_in_endpoint_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_usb_in_endpoint_control
	import usb_in_ep_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sof;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, d;
	logic e;
	token_t in_token;
	handshake_t hs_in;
	resp_t resp, r;
	fifo_wr_t fifo_wr;
	logic [3:1] ep_irq;
	int err_count, n_checks, irq_n, exp_irq, nbytes, cap;
	bit zq[$];
	logic [7:0] dq[$];
	bit tg, und, hsent, shalt, iso, forced, hd, isoupd;

	usb_in_endpoint_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .in_token(in_token), .hs_in(hs_in), .sof(sof), .resp(resp),
		.fifo_wr(fifo_wr), .ep_irq(ep_irq));
	usb_host_model host (.pclk(pclk), .resp(resp), .in_token(in_token), .hs_in(hs_in), .sof(sof));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ************************************************************
	// checking and apb helpers
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// setup, access, hold until pready sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// low register write, model follows the field meanings
	task automatic wlow(input logic [7:0] v);
		apb(1'b1, 12'h044, {24'h0, v}, d, e);
		if (v[0] && zq.size() < cap)
		begin
			zq.push_back(nbytes == 0);
			hd = isoupd && iso;
		end
		if (v[0])
			nbytes = 0;
		und = und & v[2];
		hsent = hsent & v[5];
		shalt = v[4];
		if (v[6])
			tg = 1'b0;
		if (v[3] && zq.size() > 0)
		begin
			void'(zq.pop_front());
			exp_irq++;
		end
	endtask : wlow

	// high register write with read back of the defined bits
	task automatic whigh(input logic [7:0] v);
		apb(1'b1, 12'h048, {24'h0, v}, d, e);
		apb(1'b0, 12'h048, 32'h0, d, e);
		chk(d, {24'h0, v & 8'hec});
		iso = v[6];
		forced = v[3];
		cap = v[7] ? 2 : 1;
	endtask : whigh

	// one random byte into the packet memory
	task automatic wdata;
		seed = lfsr(seed);
		dq.push_back(seed[7:0]);
		nbytes++;
		apb(1'b1, 12'h080, {24'h0, seed[7:0]}, d, e);
	endtask : wdata

	// low register, toggle status and interrupt count against the model
	task automatic chk_low;
		apb(1'b0, 12'h044, 32'h0, d, e);
		chk(d, {26'h0, hsent, shalt, 1'b0, und, zq.size() > 0, zq.size() == cap && !hd});
		apb(1'b0, 12'h04c, 32'h0, d, e);
		chk(d, {31'h0, tg});
		chk({31'h0, e}, 32'h0);
		chk(irq_n, exp_irq);
	endtask : chk_low

	// one in token on endpoint one, answer predicted by the model
	task automatic do_in(input logic ack);
		resp_kind_t k;
		int avail;
		avail = zq.size() - hd;
		if (!iso && shalt)
			k = RESP_STALL;
		else if (avail > 0)
			k = zq[0] ? RESP_ZLP : RESP_DATA;
		else
			k = iso ? RESP_ZLP : RESP_NAK;
		seed = lfsr(seed);
		host.xfer(2'd1, !iso, ack, 1 + seed[1:0], r);
		chk({r.valid, r.kind, r.toggle, r.ep}, {1'b1, k, tg, 2'd1});
		if (k == RESP_STALL)
		begin
			hsent = 1'b1;
			zq.delete();
			exp_irq++;
		end
		else if (k == RESP_NAK)
			und = 1'b1;
		else
		begin
			if (avail == 0)
				und = 1'b1;
			else if (iso || ack)
			begin
				void'(zq.pop_front());
				exp_irq++;
			end
			if (forced || (!iso && ack))
				tg = ~tg;
		end
	endtask : do_in

	// packet memory writes and interrupt pulses
	always @(posedge pclk)
	begin
		if (fifo_wr.en === 1'b1)
			chk({fifo_wr.ep, fifo_wr.data}, {2'd1, dq.pop_front()});
		if (ep_irq[1] === 1'b1)
			irq_n++;
		// only endpoint one is ever exercised
		if (ep_irq[3:2] !== 2'b00)
			chk({30'h0, ep_irq[3:2]}, 32'h0);
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = '0;
		pwdata = '0;
		seed = 32'h08b22faa;
		{err_count, n_checks, irq_n, exp_irq, nbytes} = '0;
		cap = 1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h044, 32'h0, d, e);
		chk(d, 32'h0);
		apb(1'b1, 12'h044, 32'h10, d, e);
		apb(1'b0, 12'h044, 32'h0, d, e);
		chk(d, 32'h0);
		apb(1'b0, 12'h3fc, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
		chk(d, 32'h0);
		apb(1'b1, 12'h038, 32'h1, d, e);
		host.xfer(2'd1, 1'b1, 1'b1, 1, r);
		chk(r.valid, 32'h0);
		wlow(8'ha4);
		chk_low();
		whigh(8'h20);
		apb(1'b1, 12'h038, 32'h2, d, e);
		apb(1'b0, 12'h048, 32'h0, d, e);
		chk(d, 32'h0);
		apb(1'b1, 12'h038, 32'h1, d, e);
		do_in(1'b1);
		chk_low();
		wlow(8'h20);
		chk_low();
		repeat (3) wdata();
		wlow(8'h25);
		chk_low();
		do_in(1'b1);
		chk_low();
		wlow(8'h25);
		do_in(1'b1);
		chk_low();
		whigh(8'h28);
		wdata();
		wlow(8'h25);
		do_in(1'b0);
		chk_low();
		// clear toggle from one, next packet carries zero
		wlow(8'h64);
		chk_low();
		do_in(1'b1);
		chk_low();
		whigh(8'h04);
		wdata();
		wlow(8'h35);
		do_in(1'b1);
		chk_low();
		wlow(8'h04);
		chk_low();
		// flush one packet, then flush on empty
		wdata();
		wlow(8'h25);
		wlow(8'h25);
		wlow(8'h2c);
		chk_low();
		wlow(8'h2c);
		chk_low();
		// double buffer, first commit frees flag silently
		whigh(8'ha0);
		wdata();
		wlow(8'h25);
		chk_low();
		wdata();
		wlow(8'h25);
		chk_low();
		do_in(1'b1);
		do_in(1'b1);
		chk_low();
		// iso endpoint set up double buffered
		whigh(8'he0);
		do_in(1'b1);
		chk_low();
		// halt has no effect in iso
		wdata();
		wlow(8'h35);
		do_in(1'b1);
		wlow(8'h20);
		chk_low();
		apb(1'b1, 12'h004, 32'h80, d, e);
		isoupd = 1'b1;
		wdata();
		wlow(8'h25);
		do_in(1'b1);
		host.frame();
		hd = 1'b0;
		do_in(1'b1);
		chk_low();
		report_and_stop();
	end
endmodule : tb_usb_in_endpoint_control
`default_nettype wire
